/* src/rsp_pkg.sv */
package rsp_pkg;

   // Local clock and link timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int SCLK_HALF_NS  = 500;
   localparam int CE_SETUP_NS   = 1000;
   localparam int CE_HOLD_NS    = 60;
   localparam int CE_IDLE_NS    = 1000;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CE_SETUP_CYC  =
      (CE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CE_HOLD_CYC   =
      (CE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CE_IDLE_CYC   =
      (CE_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W         = 6;
   localparam logic [TMR_W-1:0] SCLK_HALF_LAST = TMR_W'(SCLK_HALF_CYC - 1);
   localparam logic [TMR_W-1:0] CE_SETUP_LAST  = TMR_W'(CE_SETUP_CYC - 1);
   localparam logic [TMR_W-1:0] CE_HOLD_LAST   = TMR_W'(CE_HOLD_CYC - 1);
   localparam logic [TMR_W-1:0] CE_IDLE_LAST   = TMR_W'(CE_IDLE_CYC - 1);

   // Byte layout
   localparam int BYTE_W  = 8;
   localparam int DIR_BIT = 7;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Address ranges and wrap points
   localparam logic [7:0] CLK_RD_FIRST = 8'h00;
   localparam logic [7:0] CLK_RD_LAST  = 8'h1f;
   localparam logic [7:0] RAM_RD_FIRST = 8'h20;
   localparam logic [7:0] RAM_RD_LAST  = 8'h7f;
   localparam logic [7:0] CLK_WR_FIRST = 8'h80;
   localparam logic [7:0] CLK_WR_LAST  = 8'h9f;
   localparam logic [7:0] RAM_WR_FIRST = 8'ha0;
   localparam logic [7:0] RAM_WR_LAST  = 8'hff;

   // Write data buffer
   localparam int FIFO_DEPTH = 32;

   // Pointer step with range wrap
   function automatic logic [7:0] rsp_next_addr(input logic [7:0] a);
      unique case (a)
         CLK_RD_LAST: rsp_next_addr = CLK_RD_FIRST;
         RAM_RD_LAST: rsp_next_addr = RAM_RD_FIRST;
         CLK_WR_LAST: rsp_next_addr = CLK_WR_FIRST;
         RAM_WR_LAST: rsp_next_addr = RAM_WR_FIRST;
         default:     rsp_next_addr = 8'(a + 8'h01);
      endcase
   endfunction : rsp_next_addr

endpackage : rsp_pkg

/* src/rsp_link_if.sv */
`timescale 1ns/1ns
interface rsp_link_if (
   input wire logic interface_select_pin
);
   logic chip_en;
   logic sclk;
   logic host_dout;
   logic host_doe;
   logic dev_dout;
   logic dev_doe;
   logic shared_line;
   logic serial_in_line;
   logic serial_out_line;

   // One line in three-wire mode, pulled high when nobody drives
   assign shared_line     = dev_doe ? dev_dout : (host_doe ? host_dout : 1'b1);
   assign serial_in_line  = interface_select_pin ? host_dout : shared_line;
   assign serial_out_line = interface_select_pin ?
                            (dev_doe ? dev_dout : 1'b1) : shared_line;

   modport dev (
      input  chip_en,
      input  sclk,
      input  serial_in_line,
      input  interface_select_pin,
      output dev_dout,
      output dev_doe
   );

   modport host (
      output chip_en,
      output sclk,
      output host_dout,
      output host_doe,
      input  serial_out_line,
      input  interface_select_pin
   );
endinterface : rsp_link_if

/* src/rsp_dev.sv */
`timescale 1ns/1ns
// How it works
// - First eight bits after select are address
// - Address top bit: 0 read, 1 write
// - Single transfer: address, one byte, deselect
// - Pointer advances after every data byte
// - Clock read burst wraps 1Fh to 00h
// - Clock write burst wraps 9Fh to 80h
// - RAM read burst wraps 7Fh to 20h
// - RAM write burst wraps FFh to A0h
// - Burst: select held, eight clocks per byte
// - Three-wire mode shares one data line
// - Three-wire bytes travel LSB first
// - Three-wire: sample rising, drive falling
// - Select pin high SPI, low three-wire
// - SPI idle polarity caught at select
// - SPI bytes MSB first, clock per bit
module rsp_dev
   import rsp_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // Serial link
   rsp_link_if.dev          link,
   // Memory side
   output logic [7:0]       mem_addr,
   output logic [7:0]       mem_wdata,
   output logic             mem_we,
   output logic             mem_re,
   input  wire logic [7:0]  mem_rdata,
   // Status
   output logic             xfer_active,
   output logic             xfer_write
);

   typedef enum logic [1:0] {RSP_IDLE, RSP_ADDR, RSP_DATA} rsp_dev_state_t;

   rsp_dev_state_t state;
   logic           ce_m;
   logic           ce_s;
   logic           sck_m;
   logic           sck_s;
   logic           sck_d;
   logic           din_m;
   logic           din_s;
   logic           sel_m;
   logic           sel_s;
   logic           spi_mode;
   logic           cpol;
   logic [2:0]     cnt;
   logic [7:0]     rsr;
   logic [7:0]     tsr;
   logic [7:0]     ptr;
   logic           wr;
   logic           re_d;
   logic           dout;
   logic           doe;
   logic           active;
   logic           sck_rise;
   logic           sck_fall;
   logic           strobe;
   logic           shift_e;
   logic           byte_done;
   logic [7:0]     next_rsr;

   // Pin synchronisers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ce_m  <= 1'b0;
         ce_s  <= 1'b0;
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_d <= 1'b0;
         din_m <= 1'b0;
         din_s <= 1'b0;
         sel_m <= 1'b0;
         sel_s <= 1'b0;
      end else begin
         ce_m  <= link.chip_en;
         ce_s  <= ce_m;
         sck_m <= link.sclk;
         sck_s <= sck_m;
         sck_d <= sck_s;
         din_m <= link.serial_in_line;
         din_s <= din_m;
         sel_m <= link.interface_select_pin;
         sel_s <= sel_m;
      end
   end

   // Edge roles depend on mode and captured idle level
   always_comb begin
      active   = (state != RSP_IDLE) && ce_s;
      sck_rise = sck_s && !sck_d;
      sck_fall = !sck_s && sck_d;
      if (spi_mode) begin
         strobe  = active && (cpol ? sck_rise : sck_fall);
         shift_e = active && (cpol ? sck_fall : sck_rise);
      end else begin
         strobe  = active && sck_rise;
         shift_e = active && sck_fall;
      end
      byte_done = strobe && (cnt == LAST_BIT);
      if (spi_mode) begin
         next_rsr = {rsr[6:0], din_s};
      end else begin
         next_rsr = {din_s, rsr[7:1]};
      end
   end

   // Frame sequencing and address pointer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state    <= RSP_IDLE;
         cnt      <= 3'h0;
         rsr      <= 8'h00;
         ptr      <= 8'h00;
         wr       <= 1'b0;
         spi_mode <= 1'b1;
         cpol     <= 1'b0;
      end else if (!ce_s) begin
         state <= RSP_IDLE;
         cnt   <= 3'h0;
         wr    <= 1'b0;
      end else begin
         unique case (state)
            RSP_IDLE: begin
               state    <= RSP_ADDR;
               cnt      <= 3'h0;
               spi_mode <= sel_s;
               cpol     <= sck_s;
            end
            RSP_ADDR, RSP_DATA: begin
               if (strobe) begin
                  rsr <= next_rsr;
                  cnt <= 3'(cnt + 3'h1);
               end
               if (byte_done && state == RSP_ADDR) begin
                  ptr   <= next_rsr;
                  wr    <= next_rsr[DIR_BIT];
                  state <= RSP_DATA;
               end else if (byte_done) begin
                  ptr <= rsp_next_addr(ptr);
               end
            end
         endcase
      end
   end

   // Memory requests at byte boundaries
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mem_addr  <= 8'h00;
         mem_wdata <= 8'h00;
         mem_we    <= 1'b0;
         mem_re    <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         if (byte_done && state == RSP_ADDR && !next_rsr[DIR_BIT]) begin
            mem_re   <= 1'b1;
            mem_addr <= next_rsr;
         end else if (byte_done && state == RSP_DATA && wr) begin
            mem_we    <= 1'b1;
            mem_addr  <= ptr;
            mem_wdata <= next_rsr;
         end else if (byte_done && state == RSP_DATA) begin
            // Prefetch the next location of the burst
            mem_re   <= 1'b1;
            mem_addr <= rsp_next_addr(ptr);
         end
      end
   end

   // Read data shifter and output driver
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         re_d <= 1'b0;
         tsr  <= 8'h00;
         dout <= 1'b1;
         doe  <= 1'b0;
      end else begin
         re_d <= mem_re;
         if (!ce_s) begin
            doe <= 1'b0;
         end else if (re_d) begin
            tsr <= mem_rdata;
         end else if (shift_e && state == RSP_DATA && !wr) begin
            doe <= 1'b1;
            if (spi_mode) begin
               dout <= tsr[7];
               tsr  <= {tsr[6:0], 1'b0};
            end else begin
               dout <= tsr[0];
               tsr  <= {1'b0, tsr[7:1]};
            end
         end
      end
   end

   // Status flags
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         xfer_active <= 1'b0;
         xfer_write  <= 1'b0;
      end else begin
         xfer_active <= active;
         xfer_write  <= wr;
      end
   end

   // Shared line is resolved in the interface
   assign link.dev_dout = dout;
   assign link.dev_doe  = doe;

endmodule : rsp_dev

/* src/rsp_host.sv */
`timescale 1ns/1ns
module rsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;
   logic [AW:0]      next_count;

   always_comb begin
      push       = in_valid && in_ready;
      pop        = out_valid && out_ready;
      next_count = count;
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wptr      <= '0;
         rptr      <= '0;
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wptr <= AW'(wptr + 1'b1);
         end
         if (pop) begin
            rptr <= AW'(rptr + 1'b1);
         end
         count     <= next_count;
         in_ready  <= next_count != (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end

   assign out_data = mem[rptr];

endmodule : rsp_fifo

module rsp_host
   import rsp_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // Serial link
   rsp_link_if.host         link,
   // Command
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [7:0]  cmd_addr,
   input  wire logic [7:0]  cmd_count,
   input  wire logic        cfg_cpol,
   // Write data
   input  wire logic        wd_valid,
   output logic             wd_ready,
   input  wire logic [7:0]  wd_data,
   // Read data and completion
   output logic             rd_valid,
   output logic [7:0]       rd_data,
   output logic             done
);

   typedef enum logic [2:0] {
      RSP_H_IDLE, RSP_H_SETUP, RSP_H_BYTE, RSP_H_HALF1, RSP_H_HALF2,
      RSP_H_STALL, RSP_H_HOLD, RSP_H_GAP
   } rsp_host_state_t;

   rsp_host_state_t  state;
   logic [TMR_W-1:0] tmr;
   logic             sel_m;
   logic             spi;
   logic             sdo_m;
   logic             sdo_s;
   logic             cpol;
   logic             sclk;
   logic             ce;
   logic             hdout;
   logic             hdoe;
   logic [7:0]       hsr;
   logic [7:0]       rsr;
   logic [2:0]       bitn;
   logic [7:0]       left;
   logic             is_addr;
   logic             wr;
   logic             fifo_valid;
   logic [7:0]       fifo_data;
   logic             fifo_pop;
   logic [7:0]       next_rsr;
   logic             tick;

   rsp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (wd_valid),
      .in_ready  (wd_ready),
      .in_data   (wd_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sel_m <= 1'b1;
         spi   <= 1'b1;
         sdo_m <= 1'b1;
         sdo_s <= 1'b1;
      end else begin
         sel_m <= link.interface_select_pin;
         spi   <= sel_m;
         sdo_m <= link.serial_out_line;
         sdo_s <= sdo_m;
      end
   end

   always_comb begin
      tick     = (tmr == SCLK_HALF_LAST);
      fifo_pop = (state == RSP_H_STALL) && fifo_valid;
      if (spi) begin
         next_rsr = {rsr[6:0], sdo_s};
      end else begin
         next_rsr = {sdo_s, rsr[7:1]};
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state     <= RSP_H_IDLE;
         tmr       <= '0;
         cpol      <= 1'b0;
         sclk      <= 1'b0;
         ce        <= 1'b0;
         hdout     <= 1'b1;
         hdoe      <= 1'b0;
         hsr       <= 8'h00;
         rsr       <= 8'h00;
         bitn      <= 3'h0;
         left      <= 8'h00;
         is_addr   <= 1'b0;
         wr        <= 1'b0;
         cmd_ready <= 1'b0;
         rd_valid  <= 1'b0;
         rd_data   <= 8'h00;
         done      <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         done     <= 1'b0;
         tmr      <= TMR_W'(tmr + 1'b1);
         unique case (state)
            RSP_H_IDLE: begin
               cpol      <= spi && cfg_cpol;
               sclk      <= spi && cfg_cpol;
               hdoe      <= spi;
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  ce        <= 1'b1;
                  hsr       <= cmd_addr;
                  wr        <= cmd_addr[DIR_BIT];
                  left      <= cmd_count;
                  is_addr   <= 1'b1;
                  tmr       <= '0;
                  state     <= RSP_H_SETUP;
               end
            end
            RSP_H_SETUP: begin
               if (tmr == CE_SETUP_LAST) begin
                  state <= RSP_H_BYTE;
               end
            end
            RSP_H_BYTE: begin
               bitn <= 3'h0;
               tmr  <= '0;
               hdoe <= spi || is_addr || wr;
               if (!spi) begin
                  hdout <= hsr[0];
                  hsr   <= {1'b0, hsr[7:1]};
               end
               state <= RSP_H_HALF1;
            end
            RSP_H_HALF1: begin
               if (tick) begin
                  sclk  <= ~sclk;
                  tmr   <= '0;
                  state <= RSP_H_HALF2;
                  if (spi) begin
                     hdout <= hsr[7];
                     hsr   <= {hsr[6:0], 1'b0};
                  end else begin
                     rsr <= next_rsr;
                  end
               end
            end
            RSP_H_HALF2: begin
               if (tick) begin
                  sclk <= ~sclk;
                  tmr  <= '0;
                  if (spi) begin
                     rsr <= next_rsr;
                  end else if (bitn != LAST_BIT) begin
                     hdout <= hsr[0];
                     hsr   <= {1'b0, hsr[7:1]};
                  end
                  bitn  <= 3'(bitn + 3'h1);
                  state <= RSP_H_HALF1;
                  if (bitn == LAST_BIT) begin
                     is_addr <= 1'b0;
                     if (!is_addr && !wr) begin
                        rd_valid <= 1'b1;
                        rd_data  <= spi ? next_rsr : rsr;
                     end
                     if (!spi && !wr) begin
                        hdoe <= 1'b0;
                     end
                     // Address byte never ends the frame
                     if (!is_addr && left == 8'h00) begin
                        state <= RSP_H_HOLD;
                     end else begin
                        if (!is_addr) begin
                           left <= 8'(left - 8'h01);
                        end
                        state <= wr ? RSP_H_STALL : RSP_H_BYTE;
                     end
                  end
               end
            end
            RSP_H_STALL: begin
               // Select stays high while waiting for write data
               if (fifo_valid) begin
                  hsr   <= fifo_data;
                  state <= RSP_H_BYTE;
               end
            end
            RSP_H_HOLD: begin
               if (tmr == CE_HOLD_LAST) begin
                  ce    <= 1'b0;
                  tmr   <= '0;
                  state <= RSP_H_GAP;
               end
            end
            RSP_H_GAP: begin
               hdoe <= spi;
               if (tmr == CE_IDLE_LAST) begin
                  done  <= 1'b1;
                  state <= RSP_H_IDLE;
               end
            end
         endcase
      end
   end

   assign link.chip_en   = ce;
   assign link.sclk      = sclk;
   assign link.host_dout = hdout;
   assign link.host_doe  = hdoe;

endmodule : rsp_host

/* verif/rsp_link_asserts.sv */
`timescale 1ns/1ns
module rsp_link_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Link signals
   input wire logic interface_select_pin,
   input wire logic chip_en,
   input wire logic sclk,
   input wire logic host_dout,
   input wire logic host_doe,
   input wire logic dev_dout,
   input wire logic dev_doe
);
   logic       sclk_q;
   logic       idle_lvl;
   logic       shift_lvl;
   logic [9:0] ecnt;

   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   always_ff @(posedge mclk) begin
      sclk_q <= sclk;
   end
   // Link clock edges seen in the current frame
   always_ff @(posedge mclk) begin
      if (sys_rst || !chip_en) ecnt <= 10'h000;
      else if (sclk != sclk_q) ecnt <= ecnt + 10'h001;
   end
   always_ff @(posedge mclk) begin
      if (!chip_en) idle_lvl <= sclk;
   end
   assign shift_lvl = interface_select_pin ? !idle_lvl : 1'b0;

   deselect_release_a: assert property (!chip_en [*6] |-> !dev_doe)
      else $error("device drives the line after deselect");
   line_contention_a: assert property (
      !interface_select_pin |-> !(dev_doe && host_doe))
      else $error("both ends drive the shared line");
   address_quiet_a: assert property (
      chip_en && ecnt < 10'h00f |-> !dev_doe)
      else $error("device drives during the address byte");
   read_start_a: assert property (
      $rose(dev_doe) |-> ecnt inside {10'h010, 10'h011})
      else $error("read data not started after address");
   dev_shift_a: assert property (
      dev_doe && $changed(dev_dout) |-> sclk == shift_lvl)
      else $error("device data moved off the shift edge");
   host_shift_a: assert property (
      chip_en && host_doe && $changed(host_dout) &&
      ecnt inside {[10'h001:10'h00e]} |-> sclk == shift_lvl)
      else $error("host data moved off the shift edge");
   ce_setup_a: assert property ($rose(chip_en) |=> $stable(sclk) [*8])
      else $error("link clock moved right after select");
   whole_bytes_a: assert property (
      $fell(chip_en) |-> ecnt[3:0] == 4'h0 && ecnt >= 10'h020)
      else $error("frame ended inside a byte");
endmodule : rsp_link_asserts

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import rsp_pkg::*;
   logic        mclk, sys_rst, isp, cmd_valid, cmd_ready, cfg_cpol;
   logic        wd_valid, wd_ready, rd_valid, done, mem_we, mem_re;
   logic        xfer_active, xfer_write, sq, idle;
   logic [7:0]  cmd_addr, cmd_count, wd_data, rd_data, ab;
   logic [7:0]  mem_addr, mem_wdata, mem_rdata;
   logic [7:0]  mem [256];
   logic [7:0]  rd_q[$], wexp[$], sq_d[$];
   logic [15:0] wr_q[$];
   logic [31:0] lfsr;
   int          mismatches = 0;
   int          total_checks = 0;
   int          nb = 0;

   rsp_link_if rsp_link_if_i (.interface_select_pin(isp));
   rsp_dev rsp_dev_i (.mclk(mclk), .sys_rst(sys_rst), .link(rsp_link_if_i),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .mem_re(mem_re), .mem_rdata(mem_rdata), .xfer_active(xfer_active),
      .xfer_write(xfer_write));
   rsp_host rsp_host_i (.mclk(mclk), .sys_rst(sys_rst), .link(rsp_link_if_i),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
      .cmd_count(cmd_count), .cfg_cpol(cfg_cpol), .wd_valid(wd_valid),
      .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .done(done));
   rsp_link_asserts rsp_link_asserts_i (.mclk(mclk), .sys_rst(sys_rst),
      .interface_select_pin(isp), .chip_en(rsp_link_if_i.chip_en),
      .sclk(rsp_link_if_i.sclk), .host_dout(rsp_link_if_i.host_dout),
      .host_doe(rsp_link_if_i.host_doe), .dev_dout(rsp_link_if_i.dev_dout),
      .dev_doe(rsp_link_if_i.dev_doe));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rnd

   function automatic logic [7:0] step(input logic [7:0] a);
      case (a)
         8'h1f: return 8'h00;
         8'h7f: return 8'h20;
         8'h9f: return 8'h80;
         8'hff: return 8'ha0;
         default: return a + 8'h01;
      endcase
   endfunction : step

   task automatic fail(input string msg);
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask : fail

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) fail($sformatf("saw %h expected %h", seen, exp));
   endtask : chk

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         fail("wait ran out");
         finish_test();
      end
   endtask : guard

   // Memory behind the device; writes land at the matching read address
   always @(posedge mclk) begin
      if (mem_we === 1'b1) begin
         chk(16'(xfer_write), 16'h0001);
         chk(16'(xfer_active), 16'h0001);
         if (wr_q.size() == 0) fail("extra write");
         else chk({mem_addr, mem_wdata}, wr_q.pop_front());
         mem[{1'b0, mem_addr[6:0]}] <= mem_wdata;
      end
      if (mem_re === 1'b1) begin
         chk(16'(xfer_write), 16'h0000);
         mem_rdata <= mem[mem_addr];
      end
      if (rd_valid === 1'b1) begin
         if (rd_q.size() == 0) fail("extra read");
         else chk(16'(rd_data), 16'(rd_q.pop_front()));
      end
   end

   // Address byte as it crosses the wire, at each strobe edge
   always @(posedge mclk) begin
      if (rsp_link_if_i.chip_en !== 1'b1) begin
         nb = 0;
         idle = rsp_link_if_i.sclk;
      end else if (rsp_link_if_i.sclk !== sq && nb < 8 &&
                   rsp_link_if_i.sclk === (isp ? idle : 1'b1)) begin
         ab = isp ? {ab[6:0], rsp_link_if_i.serial_in_line}
                  : {rsp_link_if_i.serial_in_line, ab[7:1]};
         nb++;
         if (nb == 8) chk(16'(ab), 16'(cmd_addr));
      end
      sq = rsp_link_if_i.sclk;
   end

   task automatic push_wd(input logic [7:0] d);
      int n;
      n = 0;
      wd_valid = 1'b1;
      wd_data = d;
      @(posedge mclk);
      while (wd_ready !== 1'b1 && n < 9000) begin
         n++;
         @(posedge mclk);
      end
      #1 guard(n, 9000);
   endtask : push_wd

   task automatic feed(input int cnt);
      logic [7:0] d;
      for (int i = 0; i < cnt; i++) begin
         d = rnd();
         wexp.push_back(d);
         push_wd(d);
      end
      wd_valid = 1'b0;
   endtask : feed

   task automatic run(input logic [7:0] a, input logic [7:0] cnt);
      int n;
      logic [7:0] p;
      p = a;
      for (int i = 0; i <= cnt; i++) begin
         if (a[7]) wr_q.push_back({p, wexp.pop_front()});
         else rd_q.push_back(mem[p]);
         p = step(p);
      end
      cmd_addr = a;
      cmd_count = cnt;
      cmd_valid = 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 100);
      #1 cmd_valid = 1'b0;
      guard(n, 100);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (done !== 1'b1 && n < 20000);
      #1 guard(n, 20000);
      chk(16'(xfer_active), 16'h0000);
      chk(16'(rd_q.size() + wr_q.size()), 16'h0000);
   endtask : run

   initial begin
      lfsr = 32'h5379_d156;
      sys_rst = 1'b1;
      isp = 1'b1;
      cfg_cpol = 1'b0;
      cmd_valid = 1'b0;
      cmd_addr = 8'h00;
      cmd_count = 8'h00;
      wd_valid = 1'b0;
      wd_data = 8'h00;
      mem_rdata = 8'h00;
      for (int i = 0; i < 256; i++) mem[i] = rnd();
      repeat (4) @(posedge mclk);
      #1 sys_rst = 1'b0;
      // SPI idle low, SPI idle high, three-wire
      for (int m = 0; m < 3; m++) begin
         isp = (m < 2);
         cfg_cpol = (m == 1);
         repeat (8) @(posedge mclk);
         #1 feed(4);
         run(8'h9e, 8'h03);
         feed(3);
         run(8'hfe, 8'h02);
         run(8'h1e, 8'h03);
         run(8'h7e, 8'h02);
         feed(1);
         run(8'h85, 8'h00);
         run(8'h05, 8'h00);
         $display("mode %0d test done", m);
      end
      // Fill the write buffer until it refuses, then drain it
      feed(32);
      @(posedge mclk);
      #1 wd_data = 8'h5a;
      wd_valid = 1'b1;
      repeat (3) begin
         @(posedge mclk);
         chk(16'(wd_ready), 16'h0000);
      end
      #1 wd_valid = 1'b0;
      run(8'ha0, 8'h1f);
      $display("buffer test done");
      // Frame stalls on an empty buffer until data arrives
      for (int i = 0; i < 3; i++) begin
         sq_d.push_back(rnd());
         wexp.push_back(sq_d[i]);
      end
      fork
         run(8'hfe, 8'h02);
         begin
            repeat (400) @(posedge mclk);
            #1;
            foreach (sq_d[i]) push_wd(sq_d[i]);
            wd_valid = 1'b0;
         end
      join
      $display("stall test done");
      finish_test();
   end
endmodule : tb_top
